// ==== rtl/fpep_block_gate.v ====
// Per-block program/erase enable decode
`timescale 1ns/1ps
`include "fpep_consts.vh"
module fpep_block_gate (
    // Block select registers
    input wire [7:0] blockSelectHi,
    input wire [7:0] blockSelectLo,
    // Target block index, 0..11 (0..7 small, 8..11 large)
    input wire [3:0] targetBlock,
    // Result
    output wire blockEnabled,
    output wire allProtected
);
    // A block is writable only when its select bit is set
    assign blockEnabled = targetBlock[3] ?
        blockSelectHi[targetBlock[1:0]] : blockSelectLo[targetBlock[2:0]];
    // Fixed pattern that software uses to lock every block
    assign allProtected = (blockSelectHi == `FPEP_ALLPROT_HI) &&
        (blockSelectLo == `FPEP_ALLPROT_LO);
endmodule // fpep_block_gate

// ==== rtl/fpep_consts.vh ====
// Constants for the flash program/erase protection block
`ifndef FPEP_CONSTS_VH
`define FPEP_CONSTS_VH
// Control register bit positions
`define FPEP_WRITE_ARM_BIT 0
`define FPEP_BLOCK_CLEAR_BIT 1
`define FPEP_WRITE_CHECK_BIT 2
`define FPEP_WIPE_CHECK_BIT 3
// Reset values
`define FPEP_CTRL_RST 4'h0
`define FPEP_BSEL_HI_RST 8'h00
`define FPEP_BSEL_LO_RST 8'h00
// All-blocks-protected pattern
`define FPEP_ALLPROT_HI 8'hF0
`define FPEP_ALLPROT_LO 8'h00
// Block counts: 4 large blocks in hi, 8 small in lo
`define FPEP_NUM_BLOCKS 12
`define FPEP_HI_BLOCKS 4
// Modes
`define FPEP_MODE_IDLE 3'h0
`define FPEP_MODE_PROG 3'h1
`define FPEP_MODE_ERASE 3'h2
`define FPEP_MODE_PVER 3'h3
`define FPEP_MODE_EVER 3'h4
`define FPEP_MODE_PWVER 3'h5
// Prewrite-verify settle time, ns, and cycles at 40 ns clock (round up)
`define FPEP_PWV_SETTLE_NS 4000
`define FPEP_CLK_NS 40
`define FPEP_PWV_CYCLES ((`FPEP_PWV_SETTLE_NS + `FPEP_CLK_NS - 1) / `FPEP_CLK_NS)
`endif

// ==== rtl/fpep_core.v ====
// Flash program/erase mode control with software and hardware protection
// =========================================================
// Operating notes
// The block turns the four loose control bits and the two block
// select registers into one mode and two pulse levels. Any
// hardware protection source (reset, missing programming supply,
// low-power entry) clears every register but hardProtected, which it sets, on the same edge and
// forces the mode to idle, so a pulse can never outlive its cause.
// Software protection only blocks the program and erase modes;
// the three verify modes stay reachable so software can still
// check the array while it is locked.
// Limitation: pulse width and pacing are left to software. The
// block does not time the program or erase pulse itself; the
// settle flag is only a help for the verify wait.
// Trade-off: the settle counter restarts on every mode change,
// which costs a few flops but keeps the flag honest when software
// hops between verify modes without passing through idle.
//
`timescale 1ns/1ps
`include "fpep_consts.vh"
module fpep_core (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Protection sources
    input wire supplyAtLevel,
    input wire lowPowerMode,
    input wire softProtect,
    // Control register write port
    input wire ctrlWrite,
    input wire [3:0] ctrlData,
    input wire bselHiWrite,
    input wire [7:0] bselHiData,
    input wire bselLoWrite,
    input wire [7:0] bselLoData,
    // Flash access
    input wire [3:0] targetBlock,
    input wire readStrobe,
    input wire [7:0] arrayData,
    // Status and register readback
    output reg [3:0] flashControlReg,
    output reg [7:0] blockSelectHi,
    output reg [7:0] blockSelectLo,
    output reg [2:0] modeState,
    output reg programPulse,
    output reg erasePulse,
    output reg verifyActive,
    output reg verifySettled,
    output reg [7:0] readData,
    output reg hardProtected
);
    localparam [2:0] MODE_IDLE = `FPEP_MODE_IDLE;
    localparam [2:0] MODE_PROG = `FPEP_MODE_PROG;
    localparam [2:0] MODE_ERASE = `FPEP_MODE_ERASE;
    localparam [2:0] MODE_PVER = `FPEP_MODE_PVER;
    localparam [2:0] MODE_EVER = `FPEP_MODE_EVER;
    localparam [2:0] MODE_PWVER = `FPEP_MODE_PWVER;
    // Settle count is small; cut the integer on purpose to 8 bits
    localparam integer PWV_CYCLES_INT = `FPEP_PWV_CYCLES;
    localparam [7:0] PWV_CYCLES = PWV_CYCLES_INT[7:0];

    wire blockEnabled;
    wire allProtected;
    wire hwProt;
    reg [2:0] mode_d;
    reg [7:0] settleCnt_q;

    // =========================================================
    // Decode helpers
    // True for the three read-back check modes
    function is_verify;
        input [2:0] mode;
        begin
            is_verify = (mode == MODE_PVER) || (mode == MODE_EVER) ||
                (mode == MODE_PWVER);
        end
    endfunction

    // True when a pulse of the wanted kind may reach the target;
    // both pulses share this so the gating can never drift apart
    function pulse_ok;
        input [2:0] mode;
        input [2:0] want;
        input blkOpen;
        input lockAll;
        begin
            pulse_ok = (mode == want) && blkOpen && !lockAll;
        end
    endfunction

    // Block select decode; combinational so a new select takes
    // effect on the next edge together with the mode
    fpep_block_gate uGate (
        .blockSelectHi(blockSelectHi),
        .blockSelectLo(blockSelectLo),
        .targetBlock(targetBlock),
        .blockEnabled(blockEnabled),
        .allProtected(allProtected)
    );

    assign hwProt = reset || !supplyAtLevel || lowPowerMode;

    // =========================================================
    // Registers
    // cleared on protect; hardProtected set instead
    always @(posedge clk) begin
        if (hwProt) begin
            flashControlReg <= `FPEP_CTRL_RST;
            blockSelectHi <= `FPEP_BSEL_HI_RST;
            blockSelectLo <= `FPEP_BSEL_LO_RST;
            hardProtected <= 1'b1;
        end else begin
            hardProtected <= 1'b0;
            if (ctrlWrite) begin
                flashControlReg <= ctrlData;
            end
            // block selects ignored under protection above
            if (bselHiWrite) begin
                blockSelectHi <= bselHiData;
            end
            if (bselLoWrite) begin
                blockSelectLo <= bselLoData;
            end
        end
    end

    // =========================================================
    // Mode decode; program/erase over verify when both set
    always @* begin
        mode_d = MODE_IDLE;
        if (!hwProt) begin
            if (flashControlReg[`FPEP_WRITE_ARM_BIT]) begin
                mode_d = softProtect ? MODE_IDLE : MODE_PROG;
            end else if (flashControlReg[`FPEP_BLOCK_CLEAR_BIT]) begin
                mode_d = softProtect ? MODE_IDLE : MODE_ERASE;
            end else if (flashControlReg[`FPEP_WRITE_CHECK_BIT]) begin
                mode_d = MODE_PVER;
            end else if (flashControlReg[`FPEP_WIPE_CHECK_BIT]) begin
                mode_d = MODE_EVER;
            end else begin
                mode_d = MODE_PWVER;
            end
        end
    end

    // =========================================================
    // Mode, pulses and verify settle timer
    always @(posedge clk) begin
        if (hwProt) begin
            modeState <= MODE_IDLE;
            programPulse <= 1'b0;
            erasePulse <= 1'b0;
            verifyActive <= 1'b0;
            verifySettled <= 1'b0;
            settleCnt_q <= 8'h00;
            readData <= 8'h00;
        end else begin
            modeState <= mode_d;
            programPulse <= pulse_ok(mode_d, MODE_PROG, blockEnabled,
                allProtected);
            erasePulse <= pulse_ok(mode_d, MODE_ERASE, blockEnabled,
                allProtected);
            verifyActive <= is_verify(mode_d);
            // Timer restarts on any mode change; informs software pacing
            if (mode_d != modeState) begin
                settleCnt_q <= 8'h00;
                verifySettled <= 1'b0;
            end else if (settleCnt_q != PWV_CYCLES) begin
                settleCnt_q <= settleCnt_q + 8'h01;
            end else begin
                // Only verify modes report settled; pulses never do
                verifySettled <= is_verify(mode_d);
            end
            if (readStrobe && verifyActive) begin
                readData <= arrayData;
            end
        end
    end
endmodule // fpep_core

// ==== test/flash_program_erase_protect_test.sv ====
// Self-checking bench for the flash program/erase protect core
`timescale 1ns/1ps
module flash_program_erase_protect_test;
    reg clk = 1'h0, reset = 1'h1, supplyAtLevel = 1'h1, lowPowerMode = 1'h0;
    reg softProtect = 1'h0, ctrlWrite = 1'h0, bselHiWrite = 1'h0;
    reg bselLoWrite = 1'h0, readStrobe = 1'h0, chk = 1'h0;
    reg [3:0] ctrlData = 4'h0, targetBlock = 4'h0;
    reg [7:0] bselHiData = 8'h00, bselLoData = 8'h00, arrayData = 8'h00;
    wire [3:0] flashControlReg;
    wire [7:0] blockSelectHi, blockSelectLo, readData;
    wire [2:0] modeState;
    wire programPulse, erasePulse, verifyActive, verifySettled, hardProtected;
    int error_cnt = 0, cmp_count = 0, i;
    reg [31:0] rs = 32'hC212;
    reg [22:0] expQ[$];
    // Pulse rounded down, verify wait rounded up, at 40 ns clock
    localparam int PULSE_CYC = 15800 / 40;
    localparam int SETTLE_CYC = (4000 + 39) / 40;
    fpep_core i_fpep_core (.*);
    // =======
    // Helpers
    initial forever #20 clk = ~clk;
    function automatic [31:0] xs(input [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task cmp(input [22:0] g, e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Write all registers, then note the expected mode and pulses
    task op(input [3:0] c, input [7:0] h, l, input [3:0] b, input s);
        reg [2:0] m;
        reg en;
        m = c[0] ? 3'h1 : c[1] ? 3'h2 : c[2] ? 3'h3 : c[3] ? 3'h4 : 3'h5;
        if (s && m < 3'h3) m = 3'h0;
        en = (b < 4'h8 ? l[b[2:0]] : h[b[1:0]]) && !(h == 8'hF0 && l == 8'h00);
        @(posedge clk);
        {ctrlData, bselHiData, bselLoData, targetBlock} <= {c, h, l, b};
        {ctrlWrite, bselHiWrite, bselLoWrite, softProtect} <= {3'h7, s};
        @(posedge clk);
        {ctrlWrite, bselHiWrite, bselLoWrite} <= 3'h0;
        repeat (2) @(posedge clk);
        expQ.push_back({m >= 3'h3, m, m == 3'h1 && en, m == 3'h2 && en});
        chk <= 1'h1;
        @(posedge clk);
        chk <= 1'h0;
    endtask
    // Raise one protection source mid-program, with a write attempt
    task prot(input int k);
        op(4'h1, 8'h0F, 8'hFF, 4'h3, 1'h0);
        @(posedge clk);
        {reset, lowPowerMode, supplyAtLevel} <= {k == 2, k == 1, k != 0};
        ctrlWrite <= 1'h1;
        bselHiWrite <= 1'h1;
        repeat (10) @(posedge clk);
        #1 cmp({hardProtected, programPulse, erasePulse, flashControlReg,
            blockSelectHi, blockSelectLo}, 23'h400000);
        {reset, lowPowerMode, supplyAtLevel, ctrlWrite, bselHiWrite} <= 5'h04;
        repeat (2) @(posedge clk);
    endtask
    // Paced program loop, then prewrite verify and array reads
    task prog_seq;
        int n;
        for (n = 0; n < 6; n++) begin
            op(4'h1, 8'h0F, 8'hFF, 4'h4, 1'h0);
            repeat (PULSE_CYC - 5) @(posedge clk);
        end
        op(4'h0, 8'h0F, 8'hFF, 4'h4, 1'h0);
        #1 cmp(verifySettled, 23'h0);
        repeat (SETTLE_CYC) @(posedge clk);
        #1 cmp(verifySettled, 23'h1);
        @(posedge clk);
        arrayData <= 8'hA5;
        readStrobe <= 1'h1;
        @(posedge clk);
        readStrobe <= 1'h0;
        @(posedge clk);
        #1 cmp(readData, 23'hA5);
        op(4'h1, 8'h0F, 8'hFF, 4'h4, 1'h0);
        arrayData <= 8'h3C;
        readStrobe <= 1'h1;
        @(posedge clk);
        readStrobe <= 1'h0;
        @(posedge clk);
        #1 cmp(readData, 23'hA5);
    endtask
    // Monitor takes the oldest note when a result is due
    always @(negedge clk) if (chk)
        cmp({verifyActive, modeState, programPulse, erasePulse},
            expQ.pop_front());
    task report_and_stop;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // =========
    // Scenarios
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        for (i = 0; i < 5; i++) op(i ? 4'h1 << (i - 1) : 4'h0, 8'h0F, 8'hFF,
            4'h9, 1'h0);
        op(4'h1, 8'h0F, 8'hFF, 4'h2, 1'h1);
        op(4'h2, 8'hF0, 8'h00, 4'h5, 1'h0);
        op(4'h4, 8'hF0, 8'h00, 4'h5, 1'h0);
        for (i = 0; i < 3; i++) prot(i);
        prog_seq;
        repeat (200) begin
            rs = xs(rs);
            arrayData <= rs[7:0];
            op(rs[2] ? 4'h1 << rs[1:0] : 4'h0, rs[15:8], rs[23:16],
                4'(rs[27:24] % 12), rs[31]);
        end
        report_and_stop;
    end
    // Watchdog well past the expected run length
    initial begin
        #400000;
        error_cnt++;
        report_and_stop;
    end
endmodule // flash_program_erase_protect_test
bind fpep_core fpep_core_chk i_fpep_core_chk (.*);

// ==== test/fpep_core_assertions.sv ====
// Checker for the flash program/erase protect core
`timescale 1ns/1ps
module fpep_core_chk (
    // Watched ports
    input wire clk,
    input wire reset,
    input wire supplyAtLevel,
    input wire lowPowerMode,
    input wire softProtect,
    input wire [3:0] flashControlReg,
    input wire [7:0] blockSelectHi,
    input wire [7:0] blockSelectLo,
    input wire [2:0] modeState,
    input wire programPulse,
    input wire erasePulse,
    input wire verifyActive,
    input wire hardProtected
);
    // ==========
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire hpSrc = !supplyAtLevel || lowPowerMode;
    property p_clr; hpSrc |=> hardProtected && flashControlReg == 4'h0
        && blockSelectHi == 8'h00 && blockSelectLo == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("regs kept");
    property p_off; hpSrc [*2] |=> !programPulse && !erasePulse
        && !verifyActive; endproperty
    a_off: assert property (p_off) else $error("mode on");
    property p_soft; softProtect [*2] |-> modeState != 3'h1
        && modeState != 3'h2; endproperty
    a_soft: assert property (p_soft) else $error("soft leak");
    property p_pp; programPulse |-> modeState == 3'h1; endproperty
    a_pp: assert property (p_pp) else $error("stray program");
    property p_ep; erasePulse |-> modeState == 3'h2; endproperty
    a_ep: assert property (p_ep) else $error("stray erase");
    property p_all; (blockSelectHi == 8'hF0 && blockSelectLo == 8'h00) [*2]
        |-> !programPulse && !erasePulse; endproperty
    a_all: assert property (p_all) else $error("all-protect leak");
    property p_pwv; (flashControlReg == 4'h0 && !hpSrc) [*3]
        |-> modeState == 3'h5; endproperty
    a_pwv: assert property (p_pwv) else $error("no prewrite");
    property p_low; lowPowerMode [*2] |=> modeState == 3'h0; endproperty
    a_low: assert property (p_low) else $error("low power mode");
    cover property (programPulse);
    cover property (erasePulse);
    cover property (modeState == 3'h5);
endmodule // fpep_core_chk
